/* File: rcst_pkg.sv */
// Purpose: constants for the reset-cause and start-up time-out block
// Assumes: 25 MHz core clock, 32-bit classic Wishbone register bus
// Notes: register map, field positions, reset values and delay counts
`default_nettype none
package rcst_pkg;
   localparam int unsigned CORE_CLK_HZ = 25000000;
   localparam int unsigned PWRUP_DELAY_MS = 72;
   localparam int unsigned PWRUP_DELAY_CYCLES = (CORE_CLK_HZ / 1000) * PWRUP_DELAY_MS;
   localparam int unsigned OSC_STARTUP_PERIODS = 1024;
   localparam logic [10:0] OSC_STARTUP_LAST = 11'h3ff;
   // register byte addresses
   localparam logic [7:0] ADDR_POWER_STATUS = 8'h00;
   localparam logic [7:0] ADDR_CPU_STATUS = 8'h04;
   localparam logic [7:0] ADDR_RESET_INFO = 8'h08;
   localparam logic [7:0] ADDR_WAKE_CTRL = 8'h0c;
   // power control status fields
   localparam int BROWNOUT_FLAG_BIT = 0;
   localparam int POWERON_FLAG_BIT = 1;
   // processor status fields
   localparam int POWERDOWN_FLAG_BIT = 3;
   localparam int TIMEOUT_FLAG_BIT = 4;
   localparam logic [4:0] CPU_STATUS_POR_TOP = 5'h03;
   // reset info fields
   localparam int INFO_BUSY_BIT = 8;
   localparam int INFO_BO_VALID_BIT = 9;
   localparam int INFO_ILLEGAL_BIT = 10;
   localparam logic [12:0] PC_RESET_VECTOR = 13'h0000;
   localparam logic [12:0] PC_IRQ_VECTOR = 13'h0004;
   typedef enum logic [1:0] {OSC_LOW_POWER, OSC_STANDARD, OSC_HIGH_SPEED, OSC_RC} rcst_osc_e;
   typedef enum logic [2:0] {
      CAUSE_NONE, CAUSE_POWERON, CAUSE_BROWNOUT, CAUSE_EXT_RUN, CAUSE_EXT_SLEEP,
      CAUSE_WDT_RESET, CAUSE_WDT_WAKE, CAUSE_IRQ_WAKE
   } rcst_cause_e;
endpackage
`default_nettype wire

/* File: rcst_counter.sv */
// Purpose: loadable down-counter signalling completion
// Assumes: synchronous reset, count advances every clock or on tick
// Notes: done is a level once the count has run out
`default_nettype none
module rcst_counter #(
   parameter int WIDTH = 8
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic load,
   input wire logic [WIDTH-1:0] loadValue,
   input wire logic tick,
   output logic done
);
   logic [WIDTH-1:0] count;
   logic running;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         count <= '0;
         running <= 1'b0;
      end else if (load) begin
         count <= loadValue;
         running <= 1'b1;
      end else if (running && tick) begin
         if (count == '0) begin
            running <= 1'b0;
         end else begin
            count <= count - 1'b1;
         end
      end
   end

   assign done = !running && !load;
endmodule // rcst_counter
`default_nettype wire

/* File: rcst_sync_edge.sv */
// Purpose: rising edge detect of an event input
// Assumes: input synchronous to core_clk
// Notes: one-cycle pulse per low-to-high step
`default_nettype none
module rcst_sync_edge (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic level,
   output logic pulse
);
   logic levelDly;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         levelDly <= 1'b0;
      end else begin
         levelDly <= level;
      end
   end

   assign pulse = level && !levelDly;
endmodule // rcst_sync_edge
`default_nettype wire

/* File: rcst_reset_cause.sv */
// Purpose: reset-cause flags, start-up delay sequencing and wake/restart vector
// Assumes: reset events arrive as synchronous pulses; oscillator ticks as a strobe
// Notes: registers on classic Wishbone, one aligned 32-bit word each
// Operation
// - brown-out flag is power control bit 0, cleared on brown-out reset
// - brown-out flag invalid while brown-out detector is configured off
// - power-on flag is bit 1, cleared only by power-on reset; the code also clears it on a bus write of 0
// - power control register holds at most two status bits
// - start-up delay depends on oscillator type and reset situation
// - power-on sets time-out and power-down flags, clears power-on flag
// - power-on flag 0 with power-down flag 0 is illegal
// - brown-out, watchdog and external-run encodings of status flags
// - external reset in sleep or interrupt wake sets time-out, clears power-down
// - resets restart at address zero, wake-ups continue at next address
// - interrupt wake with global enable set jumps to interrupt vector
// - power-on/brown-out load status top 00011; external run clears top three
// - wake-ups leave special registers alone except causing flag bits
// - oscillator start-up count only in crystal modes after power-on or wake; the code also runs it after brown-out in crystal modes
// - power-up delay is forced on while brown-out detector is enabled
// - watchdog wake-up does not reset registers
//
// The register addresses and the Wishbone interface to the registers were decided locally.
`default_nettype none
module rcst_reset_cause
   import rcst_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic wb_ack_o,
   output logic wb_err_o,
   input wire logic [1:0] oscType,
   input wire logic powerup_delay_enable_n,
   input wire logic brownout_enable,
   input wire logic poweronEvent,
   input wire logic brownoutEvent,
   input wire logic external_reset_n,
   input wire logic watchdogTimeout,
   input wire logic irqWake,
   input wire logic global_irq_enable,
   input wire logic sleeping,
   input wire logic oscTick,
   input wire logic [12:0] currentPc,
   output logic coreHold,
   output logic pcLoad,
   output logic [12:0] pcValue,
   output logic wakeStrobe,
   output logic regsResetReq
);
   typedef enum logic [1:0] {ST_RUN, ST_PWRUP, ST_OSC, ST_EXT_HOLD} rcst_state_e;

   rcst_state_e state;
   logic [7:0] power_control_status;
   logic [7:0] cpuStatus;
   logic [2:0] lastCause;
   logic [1:0] cfgOsc;
   logic cfgDelayOn;
   logic cfgBrownoutEn;
   logic extPulse;
   logic extLow;
   logic busReq;
   logic addrOk;
   logic wrEn;
   logic pendingOsc;
   logic pendingVector;
   logic pendingIrqVec;
   logic pwrLoad;
   logic oscLoad;
   logic pwrDone;
   logic oscDone;
   rcst_cause_e cause;
   logic [31:0] next_rdata;

   assign extLow = !external_reset_n;

   // falling edge of external reset, as a pulse
   rcst_sync_edge extEdge (
      .core_clk(core_clk),
      .rst(rst),
      .level(extLow),
      .pulse(extPulse)
   );

   // event priority: power-on, brown-out, external, watchdog, interrupt wake
   always_comb begin
      cause = CAUSE_NONE;
      if (poweronEvent) begin
         cause = CAUSE_POWERON;
      end else if (brownoutEvent && cfgBrownoutEn) begin
         cause = CAUSE_BROWNOUT;
      end else if (extPulse) begin
         cause = sleeping ? CAUSE_EXT_SLEEP : CAUSE_EXT_RUN;
      end else if (watchdogTimeout) begin
         cause = sleeping ? CAUSE_WDT_WAKE : CAUSE_WDT_RESET;
      end else if (irqWake && sleeping) begin
         cause = CAUSE_IRQ_WAKE;
      end
   end

   // configuration captured when a sequence is launched
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cfgOsc <= OSC_STANDARD;
         cfgDelayOn <= 1'b1;
         cfgBrownoutEn <= 1'b0;
      end else if (state == ST_RUN) begin
         cfgOsc <= oscType;
         cfgDelayOn <= !powerup_delay_enable_n || brownout_enable;
         cfgBrownoutEn <= brownout_enable;
      end
   end

   rcst_counter #(.WIDTH(21)) pwrupTimer (
      .core_clk(core_clk),
      .rst(rst),
      .load(pwrLoad),
      .loadValue(21'(PWRUP_DELAY_CYCLES - 1)),
      .tick(1'b1),
      .done(pwrDone)
   );

   rcst_counter #(.WIDTH(11)) oscStartup (
      .core_clk(core_clk),
      .rst(rst),
      .load(oscLoad),
      .loadValue(OSC_STARTUP_LAST),
      .tick(oscTick),
      .done(oscDone)
   );

   // sequencer: power-up delay, then oscillator count, then release
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state <= ST_RUN;
         pwrLoad <= 1'b0;
         oscLoad <= 1'b0;
         pendingOsc <= 1'b0;
      end else begin
         pwrLoad <= 1'b0;
         oscLoad <= 1'b0;
         case (state)
            ST_RUN: begin
               if (cause == CAUSE_POWERON || cause == CAUSE_BROWNOUT) begin
                  pendingOsc <= (oscType != OSC_RC);
                  if (!powerup_delay_enable_n || brownout_enable
                      || oscType == OSC_RC || cause == CAUSE_BROWNOUT) begin
                     pwrLoad <= 1'b1;
                     state <= ST_PWRUP;
                  end else begin
                     oscLoad <= 1'b1;
                     state <= ST_OSC;
                  end
               end else if ((cause == CAUSE_WDT_WAKE || cause == CAUSE_IRQ_WAKE)
                            && oscType != OSC_RC) begin
                  oscLoad <= 1'b1;
                  pendingOsc <= 1'b0;
                  state <= ST_OSC;
               end else if (cause == CAUSE_EXT_RUN || cause == CAUSE_EXT_SLEEP) begin
                  state <= ST_EXT_HOLD;
               end
            end
            ST_PWRUP: begin
               if (pwrDone && !pwrLoad) begin
                  if (pendingOsc) begin
                     oscLoad <= 1'b1;
                     state <= ST_OSC;
                  end else begin
                     state <= extLow ? ST_EXT_HOLD : ST_RUN;
                  end
               end
            end
            ST_OSC: begin
               if (oscDone && !oscLoad) begin
                  state <= extLow ? ST_EXT_HOLD : ST_RUN;
               end
            end
            ST_EXT_HOLD: begin
               if (!extLow) begin
                  state <= ST_RUN;
               end
            end
            default: begin
               state <= ST_RUN;
            end
         endcase
      end
   end

   // power control status flags
   always_ff @(posedge core_clk) begin
      if (rst) begin
         power_control_status <= 8'h00;
      end else if (cause == CAUSE_POWERON) begin
         power_control_status[POWERON_FLAG_BIT] <= 1'b0;
      end else if (cause == CAUSE_BROWNOUT) begin
         power_control_status[BROWNOUT_FLAG_BIT] <= 1'b0;
      end else if (wrEn && wb_adr_i[7:0] == ADDR_POWER_STATUS && wb_sel_i[0]) begin
         power_control_status[1:0] <= wb_dat_i[1:0];
      end
   end

   // processor status flags
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cpuStatus <= {CPU_STATUS_POR_TOP, 3'h0};
      end else begin
         case (cause)
            CAUSE_POWERON, CAUSE_BROWNOUT: begin
               cpuStatus[7:3] <= CPU_STATUS_POR_TOP;
            end
            CAUSE_EXT_RUN: begin
               cpuStatus[7:5] <= 3'h0;
            end
            CAUSE_EXT_SLEEP: begin
               cpuStatus[7:5] <= 3'h0;
               cpuStatus[TIMEOUT_FLAG_BIT] <= 1'b1;
               cpuStatus[POWERDOWN_FLAG_BIT] <= 1'b0;
            end
            CAUSE_WDT_RESET: begin
               cpuStatus[7:5] <= 3'h0;
               cpuStatus[TIMEOUT_FLAG_BIT] <= 1'b0;
               cpuStatus[POWERDOWN_FLAG_BIT] <= 1'b1;
            end
            CAUSE_WDT_WAKE: begin
               cpuStatus[TIMEOUT_FLAG_BIT] <= 1'b0;
               cpuStatus[POWERDOWN_FLAG_BIT] <= 1'b0;
            end
            CAUSE_IRQ_WAKE: begin
               cpuStatus[TIMEOUT_FLAG_BIT] <= 1'b1;
               cpuStatus[POWERDOWN_FLAG_BIT] <= 1'b0;
            end
            default: begin
               if (wrEn && wb_adr_i[7:0] == ADDR_CPU_STATUS && wb_sel_i[0]) begin
                  cpuStatus[7:5] <= wb_dat_i[7:5];
                  cpuStatus[2:0] <= wb_dat_i[2:0];
               end
            end
         endcase
      end
   end

   // remember the cause for software and the restart vector
   always_ff @(posedge core_clk) begin
      if (rst) begin
         lastCause <= CAUSE_NONE;
         pendingVector <= 1'b0;
         pendingIrqVec <= 1'b0;
      end else if (cause != CAUSE_NONE) begin
         lastCause <= cause;
         pendingVector <= 1'b1;
         pendingIrqVec <= (cause == CAUSE_IRQ_WAKE) && global_irq_enable;
      end else if (pcLoad) begin
         pendingVector <= 1'b0;
      end
   end

   // program counter load on release of the core
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pcLoad <= 1'b0;
         pcValue <= PC_RESET_VECTOR;
         wakeStrobe <= 1'b0;
         regsResetReq <= 1'b0;
         coreHold <= 1'b1;
      end else begin
         coreHold <= (state != ST_RUN) || (cause != CAUSE_NONE);
         pcLoad <= 1'b0;
         wakeStrobe <= 1'b0;
         regsResetReq <= (cause != CAUSE_NONE) && (cause != CAUSE_WDT_WAKE)
                         && (cause != CAUSE_IRQ_WAKE);
         if (pendingVector && !pcLoad && state == ST_RUN && cause == CAUSE_NONE) begin
            pcLoad <= 1'b1;
            if (lastCause == CAUSE_WDT_WAKE || lastCause == CAUSE_IRQ_WAKE) begin
               wakeStrobe <= 1'b1;
               pcValue <= pendingIrqVec ? PC_IRQ_VECTOR : currentPc + 13'h0001;
            end else begin
               pcValue <= PC_RESET_VECTOR;
            end
         end
      end
   end

   // wishbone slave, one wait state, err on unmapped addresses
   assign busReq = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   assign addrOk = (wb_adr_i[31:8] == 24'h000000) && (wb_adr_i[1:0] == 2'h0)
                   && (wb_adr_i[7:0] <= ADDR_WAKE_CTRL);
   assign wrEn = busReq && addrOk && wb_we_i;

   always_comb begin
      next_rdata = 32'h00000000;
      case (wb_adr_i[7:0])
         ADDR_POWER_STATUS: next_rdata[1:0] = power_control_status[1:0];
         ADDR_CPU_STATUS: next_rdata[7:0] = cpuStatus;
         ADDR_RESET_INFO: begin
            next_rdata[2:0] = lastCause;
            next_rdata[INFO_BUSY_BIT] = (state != ST_RUN);
            next_rdata[INFO_BO_VALID_BIT] = cfgBrownoutEn;
            next_rdata[INFO_ILLEGAL_BIT] = !power_control_status[POWERON_FLAG_BIT]
               && (!cpuStatus[TIMEOUT_FLAG_BIT] || !cpuStatus[POWERDOWN_FLAG_BIT]);
         end
         ADDR_WAKE_CTRL: next_rdata[12:0] = currentPc;
         default: next_rdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= busReq && addrOk;
         wb_err_o <= busReq && !addrOk;
         wb_dat_o <= (busReq && addrOk && !wb_we_i) ? next_rdata : 32'h00000000;
      end
   end
endmodule // rcst_reset_cause
`default_nettype wire

/* File: rcst_reset_cause_assertions.sv */
// Purpose: port-level checks of the reset-cause block
// Assumes: one core_clk domain, synchronous active-high rst
// Notes: bound onto every rcst_reset_cause instance
`default_nettype none
module rcst_reset_cause_assertions
   import rcst_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [31:0] wb_adr_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic wb_err_o,
   input wire logic [1:0] oscType,
   input wire logic brownout_enable,
   input wire logic poweronEvent,
   input wire logic brownoutEvent,
   input wire logic external_reset_n,
   input wire logic watchdogTimeout,
   input wire logic irqWake,
   input wire logic sleeping,
   input wire logic [12:0] currentPc,
   input wire logic coreHold,
   input wire logic pcLoad,
   input wire logic [12:0] pcValue,
   input wire logic wakeStrobe,
   input wire logic regsResetReq
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   logic taken;
   assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   sequence xtalWake;
      sleeping && (watchdogTimeout || irqWake) && oscType != 2'h3;
   endsequence
   sequence rcIrqWake;
      sleeping && irqWake && oscType == 2'h3 && !watchdogTimeout;
   endsequence
   sequence extRunFall;
      $fell(external_reset_n) && !sleeping;
   endsequence
   bus_answer_a: assert property (taken |=> (wb_ack_o || wb_err_o))
      else $error("bus request not answered one cycle later");
   ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   unmapped_err_a: assert property (taken && (wb_adr_i > 32'hc || wb_adr_i[1:0] != 2'h0)
      |=> wb_err_o && !wb_ack_o) else $error("unmapped access not refused");
   reset_vector_a: assert property (pcLoad && !wakeStrobe |-> pcValue == PC_RESET_VECTOR)
      else $error("restart not at address zero");
   wake_vector_a: assert property (pcLoad && wakeStrobe |->
      pcValue == currentPc + 13'h1 || pcValue == PC_IRQ_VECTOR) else $error("bad wake address");
   wake_pair_a: assert property (wakeStrobe |-> pcLoad) else $error("wake strobe without load");
   wake_noreset_a: assert property (xtalWake |=> !regsResetReq [*3])
      else $error("wake-up requested register reset");
   osc_wait_a: assert property (xtalWake |=> !pcLoad [*8])
      else $error("crystal wake released without start-up count");
   rc_wake_a: assert property (rcIrqWake |-> ##[1:20] pcLoad)
      else $error("rc wake not released promptly");
   ext_reset_a: assert property (extRunFall |-> ##[1:3] regsResetReq)
      else $error("external reset without register reset");
   poweron_hold_a: assert property (poweronEvent |=> coreHold [*8])
      else $error("core not held after power-on");
   brownout_hold_a: assert property (brownoutEvent && brownout_enable |=> coreHold [*8])
      else $error("core not held after brown-out");
endmodule // rcst_reset_cause_assertions
bind rcst_reset_cause rcst_reset_cause_assertions u_rcst_reset_cause_assertions (.*);
`default_nettype wire

/* File: tb_top.sv */
// Purpose: directed bench for the reset-cause block
// Assumes: classic Wishbone, 40 ns core clock
// Notes: power-up delay is too long to finish; only its start is seen
`default_nettype none
module tb_top
   import rcst_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk, rst, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, wb_err_o, errSeen;
   logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, q;
   logic [3:0] wb_sel_i;
   logic [1:0] oscType;
   logic powerup_delay_enable_n, brownout_enable, poweronEvent, brownoutEvent;
   logic external_reset_n, watchdogTimeout, irqWake, global_irq_enable, sleeping;
   logic oscTick, coreHold, pcLoad, wakeStrobe, regsResetReq, sawReq, wkSeen;
   logic [12:0] currentPc, pcValue, pcSeen;
   int n_errors, compares, n;
   rcst_reset_cause u_rcst_reset_cause (.*);
   initial begin
      core_clk = 0;
      forever #20 core_clk = ~core_clk;
   end
   always @(posedge core_clk) if (regsResetReq === 1'b1) sawReq <= 1'b1;
   task automatic test_done;
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge core_clk);
      wb_cyc_i <= 1;
      wb_stb_i <= 1;
      wb_we_i <= w;
      wb_adr_i <= {24'h0, a};
      wb_dat_i <= d;
      k = 0;
      // look mid-cycle, where the registered answer has settled
      do begin
         @(negedge core_clk);
         k++;
      end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && k < 20);
      q = wb_dat_o;
      errSeen = wb_err_o;
      if (k >= 20) begin
         n_errors++;
         $display("unexpected at %0t: bus request not answered", $time);
      end
      // release at the edge where the answer is sampled high
      @(posedge core_clk);
      wb_cyc_i <= 0;
      wb_stb_i <= 0;
      wb_we_i <= 0;
   endtask
   task automatic waitPc(input int lim);
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while (pcLoad !== 1'b1 && n < lim);
      pcSeen = pcValue;
      wkSeen = wakeStrobe;
      @(posedge core_clk);
   endtask
   task automatic t_regs;
      wb(0, ADDR_POWER_STATUS, 0); check(q, 32'h0);
      wb(0, ADDR_CPU_STATUS, 0); check(q, 32'h18);
      wb(1, ADDR_POWER_STATUS, 32'hff);
      wb(0, ADDR_POWER_STATUS, 0); check(q, 32'h3);
      wb(1, ADDR_CPU_STATUS, 32'he7);
      wb(0, ADDR_CPU_STATUS, 0); check(q, 32'hff);
      wb(0, 8'h10, 0); check({31'h0, errSeen}, 32'h1);
      $display("test registers done");
   endtask
   task automatic t_ext_run;
      sawReq = 0;
      @(posedge core_clk) external_reset_n <= 0;
      @(posedge core_clk) external_reset_n <= 1;
      waitPc(1100);
      check(32'(pcSeen), 32'h0);
      check({31'h0, sawReq}, 32'h1);
      wb(0, ADDR_CPU_STATUS, 0); check(q, 32'h1f);
      wb(0, ADDR_RESET_INFO, 0); check(q & 32'h7, 32'h3);
      @(posedge core_clk) watchdogTimeout <= 1;
      @(posedge core_clk) watchdogTimeout <= 0;
      waitPc(1100);
      check(32'(pcSeen), 32'h0);
      wb(0, ADDR_CPU_STATUS, 0); check(q, 32'h0f);
      $display("test external and watchdog reset done");
   endtask
   task automatic t_ext_sleep;
      @(posedge core_clk) sleeping <= 1;
      external_reset_n <= 0;
      @(posedge core_clk) external_reset_n <= 1;
      waitPc(1100);
      sleeping <= 0;
      check({18'h0, wkSeen, pcSeen}, 32'h0);
      wb(0, ADDR_CPU_STATUS, 0); check(q, 32'h17);
      $display("test external reset in sleep done");
   endtask
   task automatic t_wdt_wake;
      sawReq = 0;
      @(posedge core_clk) oscTick <= 0;
      sleeping <= 1;
      watchdogTimeout <= 1;
      @(posedge core_clk) watchdogTimeout <= 0;
      waitPc(40);
      check(32'(n), 32'd40);
      oscTick <= 1;
      waitPc(1100);
      sleeping <= 0;
      check({31'h0, n >= 1020 && n <= 1040}, 32'h1);
      check({17'h0, wkSeen, sawReq, pcSeen}, {17'h0, 2'b10, currentPc + 13'h1});
      wb(0, ADDR_CPU_STATUS, 0); check(q, 32'h07);
      wb(0, ADDR_POWER_STATUS, 0); check(q, 32'h3);
      wb(0, ADDR_RESET_INFO, 0); check(q & 32'h400, 32'h0);
      wb(1, ADDR_POWER_STATUS, 32'h0);
      wb(0, ADDR_RESET_INFO, 0); check(q & 32'h400, 32'h400);
      wb(1, ADDR_POWER_STATUS, 32'h3);
      $display("test watchdog wake done");
   endtask
   task automatic t_irq_wake;
      @(posedge core_clk) oscType <= OSC_RC;
      global_irq_enable <= 1;
      sleeping <= 1;
      irqWake <= 1;
      @(posedge core_clk) irqWake <= 0;
      waitPc(20);
      sleeping <= 0;
      check({31'h0, n < 20}, 32'h1);
      check(32'(pcSeen), 32'h4);
      wb(0, ADDR_CPU_STATUS, 0); check(q, 32'h17);
      @(posedge core_clk) oscType <= OSC_HIGH_SPEED;
      global_irq_enable <= 0;
      sleeping <= 1;
      irqWake <= 1;
      @(posedge core_clk) irqWake <= 0;
      waitPc(1100);
      sleeping <= 0;
      check({18'h0, wkSeen, pcSeen}, {19'h1, currentPc + 13'h1});
      $display("test interrupt wake done");
   endtask
   task automatic t_brownout;
      @(posedge core_clk) brownoutEvent <= 1;
      @(posedge core_clk) brownoutEvent <= 0;
      repeat (3) @(posedge core_clk);
      wb(0, ADDR_POWER_STATUS, 0); check(q, 32'h2);
      wb(0, ADDR_CPU_STATUS, 0); check(q & 32'h18, 32'h18);
      wb(0, ADDR_RESET_INFO, 0); check(q & 32'h207, 32'h202);
      check({31'h0, coreHold}, 32'h1);
      @(posedge core_clk) rst <= 1;
      brownout_enable <= 0;
      repeat (3) @(posedge core_clk);
      rst <= 0;
      wb(1, ADDR_POWER_STATUS, 32'h3);
      @(posedge core_clk) brownoutEvent <= 1;
      @(posedge core_clk) brownoutEvent <= 0;
      wb(0, ADDR_POWER_STATUS, 0); check(q, 32'h3);
      wb(0, ADDR_RESET_INFO, 0); check(q & 32'h200, 32'h0);
      $display("test brown-out done");
   endtask
   task automatic t_poweron;
      wb(1, ADDR_CPU_STATUS, 32'he0);
      @(posedge core_clk) poweronEvent <= 1;
      @(posedge core_clk) poweronEvent <= 0;
      wb(0, ADDR_POWER_STATUS, 0); check(q & 32'h2, 32'h0);
      wb(0, ADDR_CPU_STATUS, 0); check(q & 32'hf8, 32'h18);
      wb(0, ADDR_RESET_INFO, 0); check(q & 32'h7, 32'h1);
      repeat (200) @(posedge core_clk);
      check({31'h0, coreHold}, 32'h1);
      $display("test power-on done");
   endtask
   initial begin
      repeat (20000) @(posedge core_clk);
      n_errors++;
      test_done;
   end
   initial begin
      {rst, powerup_delay_enable_n, brownout_enable, external_reset_n, oscTick} = 5'h1f;
      {wb_we_i, wb_cyc_i, wb_stb_i, poweronEvent, brownoutEvent} = 5'h0;
      {watchdogTimeout, irqWake, global_irq_enable, sleeping, sawReq} = 5'h0;
      {wb_adr_i, wb_dat_i, wb_sel_i} = {64'h0, 4'hf};
      oscType = OSC_STANDARD;
      currentPc = 13'h0123;
      n_errors = 0;
      compares = 0;
      repeat (20) @(posedge core_clk);
      rst <= 0;
      t_regs;
      t_ext_run;
      t_ext_sleep;
      t_wdt_wake;
      t_irq_wake;
      t_brownout;
      t_poweron;
      test_done;
   end
endmodule // tb_top
`default_nettype wire
